// ==== design/pattern_gen.sv ====
// Test pattern generator for the converter and serial link output path.
// Assumes samples and register accesses synchronous to i_clk; the link
// consumer drains the output queue with valid/ready.
`timescale 1ns/100ps

module pattern_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    wire push = i_in_valid && o_in_ready;
    wire pop  = (count != '0) && (!o_out_valid || i_out_ready);
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end else begin
            wr_ptr     <= wr_ptr + AW'(push);
            rd_ptr     <= rd_ptr + AW'(pop);
            count      <= next_count;
            o_in_ready <= next_count != (AW+1)'(DEPTH);
            if (pop) begin
                o_out_valid <= 1'b1;
                o_out_data  <= mem[rd_ptr];
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end
endmodule // pattern_fifo

module pattern_gen #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [11:0] i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic        i_adc_valid,
    input  wire logic [11:0] i_adc_data,
    output logic             o_adc_ready,
    output logic             o_link_valid,
    input  wire logic        i_link_ready,
    output logic      [15:0] o_link_data,
    output logic      [1:0]  o_link_point
);
    logic [7:0]  conv_ctrl;
    logic [7:0]  user_byte [8];
    logic [7:0]  sample_ctrl;
    logic [7:0]  link_ctrl;
    logic [7:0]  layer_ctrl;
    logic [3:0]  prev_conv_code;
    logic [3:0]  prev_link_code;
    logic [31:0] conv_pn;
    logic [31:0] link_pn;
    logic [13:0] conv_word;
    logic [11:0] conv_ramp;
    logic [15:0] link_ramp;
    logic        conv_phase;
    logic        link_phase;
    logic [1:0]  conv_uidx;
    logic        conv_udone;
    logic [1:0]  link_uidx;
    logic        link_udone;
    logic        fifo_ready;
    pattern_gen_pkg::link_word_t fifo_in;
    pattern_gen_pkg::link_word_t fifo_out;

    // Advances a Fibonacci sequence n bits; bit 0 leaves first, so the
    // seed is sent from its low end; returns {word, next state} and the
    // word holds the leaving bits with the first one highest
    function automatic logic [47:0] pn_adv(input logic [31:0] s,
                                           input int len, input int tap,
                                           input int n);
        logic [31:0] v;
        logic [15:0] w;
        logic        nb;
        v  = s;
        w  = 16'h0000;
        nb = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (i < n) begin
                w        = {w[14:0], v[0]};
                nb       = v[0] ^ v[len-tap];
                v        = {1'b0, v[31:1]};
                v[len-1] = nb;
            end
        end
        return {w, v};
    endfunction

    // Register decode
    wire wr_soft   = i_reg_wr && i_reg_addr == pattern_gen_pkg::ADDR_SOFT_RESET;
    wire soft_rst  = wr_soft && i_reg_wdata == pattern_gen_pkg::SOFT_RESET_CMD;
    wire wr_conv   = i_reg_wr && i_reg_addr == pattern_gen_pkg::ADDR_CONV_TEST;
    wire wr_sample = i_reg_wr && i_reg_addr == pattern_gen_pkg::ADDR_SAMPLE_TST;
    wire wr_link   = i_reg_wr && i_reg_addr == pattern_gen_pkg::ADDR_LINK_TEST;
    wire wr_layer  = i_reg_wr && i_reg_addr == pattern_gen_pkg::ADDR_LINK_LAYER;
    wire in_user   = i_reg_addr >= pattern_gen_pkg::ADDR_USER_FIRST &&
                     i_reg_addr <= pattern_gen_pkg::ADDR_USER_LAST;
    wire [2:0] user_sel = 3'(i_reg_addr - pattern_gen_pkg::ADDR_USER_FIRST);
    // A zero write cannot leave link test mode; only a soft or hard reset clears link_ctrl
    wire link_wr_ok = wr_link && (i_reg_wdata != 8'h00 || link_ctrl == 8'h00);

    wire [3:0] conv_code   = conv_ctrl[3:0];
    wire [3:0] link_code   = link_ctrl[3:0];
    wire [1:0] link_point  = link_ctrl[5:4];
    wire       conv_single = conv_ctrl[pattern_gen_pkg::CONV_SINGLE_BIT];
    wire       pn_hold     = conv_ctrl[pattern_gen_pkg::CONV_RST_BIT_A] ||
                             conv_ctrl[pattern_gen_pkg::CONV_RST_BIT_B];
    wire       sample_test = sample_ctrl[pattern_gen_pkg::SAMPLE_TST_BIT];

    wire conv_known = conv_code inside {pattern_gen_pkg::C_MID,
        pattern_gen_pkg::C_POS, pattern_gen_pkg::C_NEG,
        pattern_gen_pkg::C_CHECK, pattern_gen_pkg::C_PNL,
        pattern_gen_pkg::C_PNS, pattern_gen_pkg::C_TOG,
        pattern_gen_pkg::C_USER, pattern_gen_pkg::C_RAMP};
    wire link_known = (link_code >= pattern_gen_pkg::L_CHECK &&
                       link_code <= pattern_gen_pkg::L_RAMP) ||
                      link_code == pattern_gen_pkg::L_UREP ||
                      link_code == pattern_gen_pkg::L_USNG;
    wire point_ok   = link_point != 2'b11;
    wire link_on    = link_known && point_ok;
    wire test_on    = conv_known || link_on;
    // Patterns advance each clock the queue accepts, analog valid or not
    wire step       = fifo_ready && (test_on || i_adc_valid);

    // Width of the injected word follows the injection point
    wire [15:0] point_mask =
        (link_point == pattern_gen_pkg::P_PHY10) ? pattern_gen_pkg::MASK_10 :
        (link_point == pattern_gen_pkg::P_SCR8)  ? pattern_gen_pkg::MASK_8  :
                                                   pattern_gen_pkg::MASK_16;
    wire [4:0] point_bits =
        (link_point == pattern_gen_pkg::P_PHY10) ? 5'd10 :
        (link_point == pattern_gen_pkg::P_SCR8)  ? 5'd8  : 5'd16;

    // Converter sequence: length and tap by code
    wire conv_long = conv_code == pattern_gen_pkg::C_PNL;
    wire [31:0] conv_seed = conv_long ? pattern_gen_pkg::SEED_PN23
                                      : pattern_gen_pkg::SEED_PN9;
    wire [47:0] conv_pn_step = conv_long ?
        pn_adv(conv_pn, 23, 18, pattern_gen_pkg::CONV_BITS) :
        pn_adv(conv_pn, 9, 5, pattern_gen_pkg::CONV_BITS);
    wire [31:0] conv_pn_next = conv_pn_step[31:0];

    // Link sequence table
    logic [31:0] link_seed;
    logic [47:0] link_pn_next;
    always_comb begin
        case (link_code)
            pattern_gen_pkg::L_PN31: begin
                link_seed    = pattern_gen_pkg::SEED_PN31;
                link_pn_next = pn_adv(link_pn, 31, 28, int'(point_bits));
            end
            pattern_gen_pkg::L_PN23: begin
                link_seed    = pattern_gen_pkg::SEED_PN23;
                link_pn_next = pn_adv(link_pn, 23, 18, int'(point_bits));
            end
            pattern_gen_pkg::L_PN15: begin
                link_seed    = pattern_gen_pkg::SEED_PN15;
                link_pn_next = pn_adv(link_pn, 15, 14, int'(point_bits));
            end
            pattern_gen_pkg::L_PN9: begin
                link_seed    = pattern_gen_pkg::SEED_PN9;
                link_pn_next = pn_adv(link_pn, 9, 5, int'(point_bits));
            end
            default: begin
                link_seed    = pattern_gen_pkg::SEED_PN7;
                link_pn_next = pn_adv(link_pn, 7, 6, int'(point_bits));
            end
        endcase
    end

    wire [15:0] conv_user = {user_byte[{conv_uidx, 1'b1}],
                             user_byte[{conv_uidx, 1'b0}]};
    wire [15:0] link_user = {user_byte[{link_uidx, 1'b1}],
                             user_byte[{link_uidx, 1'b0}]};

    // Converter pattern selection
    logic [13:0] conv_sel;
    always_comb begin
        case (conv_code)
            pattern_gen_pkg::C_MID:   conv_sel = pattern_gen_pkg::V_MID;
            pattern_gen_pkg::C_POS:   conv_sel = pattern_gen_pkg::V_POS;
            pattern_gen_pkg::C_NEG:   conv_sel = pattern_gen_pkg::V_NEG;
            pattern_gen_pkg::C_CHECK: conv_sel = conv_phase ?
                pattern_gen_pkg::V_CHK_B : pattern_gen_pkg::V_CHK_A;
            pattern_gen_pkg::C_PNL,
            pattern_gen_pkg::C_PNS:   conv_sel = conv_pn_step[45:32];
            pattern_gen_pkg::C_TOG:   conv_sel = conv_phase ?
                14'h0000 : pattern_gen_pkg::V_TOG_A;
            pattern_gen_pkg::C_USER:  conv_sel = conv_udone ?
                14'h0000 : conv_user[15:2];
            pattern_gen_pkg::C_RAMP:  conv_sel = {2'b00, conv_ramp};
            default:                  conv_sel = {2'b00, i_adc_data};
        endcase
    end
    // Sample test carries the raw converter sample untouched
    wire [13:0] next_conv_word = sample_test ? {2'b00, i_adc_data}
                                             : conv_sel;

    // Link pattern selection
    logic [15:0] link_sel;
    always_comb begin
        case (link_code)
            pattern_gen_pkg::L_CHECK: link_sel = link_phase ?
                pattern_gen_pkg::V_LCHK_B : pattern_gen_pkg::V_LCHK_A;
            pattern_gen_pkg::L_TOG:   link_sel = link_phase ?
                pattern_gen_pkg::V_LTOG_B : 16'h0000;
            pattern_gen_pkg::L_RAMP:  link_sel = link_ramp;
            pattern_gen_pkg::L_UREP:  link_sel =
                link_user >> (5'd16 - point_bits);
            pattern_gen_pkg::L_USNG:  link_sel = link_udone ? 16'h0000 :
                link_user >> (5'd16 - point_bits);
            default:                  link_sel = link_pn_next[47:32];
        endcase
    end
    wire [15:0] next_link_word = link_on ? (link_sel & point_mask)
                                         : {next_conv_word, 2'b00};

    wire [1:0] word_point = link_on ? link_point : pattern_gen_pkg::P_SAMPLE;
    assign fifo_in = '{data: next_link_word, point: word_point};

    wire conv_restart = conv_code != prev_conv_code || pn_hold;
    wire link_restart = link_code != prev_link_code || pn_hold;

    // Register file
    always_ff @(posedge i_clk) begin
        if (i_rst || soft_rst) begin
            conv_ctrl   <= pattern_gen_pkg::REG_RESET;
            sample_ctrl <= pattern_gen_pkg::REG_RESET;
            link_ctrl   <= pattern_gen_pkg::REG_RESET;
            layer_ctrl  <= pattern_gen_pkg::REG_RESET;
            for (int i = 0; i < 8; i++) begin
                user_byte[i] <= pattern_gen_pkg::REG_RESET;
            end
        end else begin
            if (wr_conv)    conv_ctrl   <= i_reg_wdata;
            if (wr_sample)  sample_ctrl <= i_reg_wdata;
            if (link_wr_ok) link_ctrl   <= i_reg_wdata;
            if (wr_layer)   layer_ctrl  <= i_reg_wdata;
            if (i_reg_wr && in_user) user_byte[user_sel] <= i_reg_wdata;
        end
    end

    wire [7:0] rd_mux =
        (i_reg_addr == pattern_gen_pkg::ADDR_CONV_TEST)  ? conv_ctrl   :
        (i_reg_addr == pattern_gen_pkg::ADDR_SAMPLE_TST) ? sample_ctrl :
        (i_reg_addr == pattern_gen_pkg::ADDR_LINK_TEST)  ? link_ctrl   :
        (i_reg_addr == pattern_gen_pkg::ADDR_LINK_LAYER) ? layer_ctrl  :
        in_user ? user_byte[user_sel] : 8'h00;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end
    end

    // Generator state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_conv_code <= 4'h0;
            prev_link_code <= 4'h0;
            conv_pn        <= pattern_gen_pkg::SEED_PN9;
            link_pn        <= pattern_gen_pkg::SEED_PN7;
            conv_ramp      <= 12'h000;
            link_ramp      <= 16'h0000;
            conv_phase     <= 1'b0;
            link_phase     <= 1'b0;
            conv_uidx      <= 2'd0;
            conv_udone     <= 1'b0;
            link_uidx      <= 2'd0;
            link_udone     <= 1'b0;
            conv_word      <= 14'h0000;
        end else begin
            prev_conv_code <= conv_code;
            prev_link_code <= link_code;
            if (conv_restart) begin
                conv_pn    <= conv_seed;
                conv_ramp  <= 12'h000;
                conv_phase <= 1'b0;
                conv_uidx  <= 2'd0;
                conv_udone <= 1'b0;
            end else if (step) begin
                conv_word      <= next_conv_word;
                conv_pn        <= conv_pn_next;
                conv_ramp      <= conv_ramp + 12'h001;
                conv_phase     <= !conv_phase;
                conv_uidx      <= conv_uidx + 2'd1;
                if (conv_uidx == 2'd3 && conv_single) conv_udone <= 1'b1;
            end
            if (link_restart) begin
                link_pn    <= link_seed;
                link_ramp  <= 16'h0000;
                link_phase <= 1'b0;
                link_uidx  <= 2'd0;
                link_udone <= 1'b0;
            end else if (step) begin
                link_pn    <= link_pn_next[31:0];
                link_ramp  <= (link_ramp + 16'h0001) & point_mask;
                link_phase <= !link_phase;
                link_uidx  <= link_uidx + 2'd1;
                if (link_uidx == 2'd3 && link_code == pattern_gen_pkg::L_USNG)
                    link_udone <= 1'b1;
            end
        end
    end

    pattern_fifo #(
        .WIDTH ($bits(pattern_gen_pkg::link_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (step && !conv_restart && !link_restart),
        .o_in_ready  (fifo_ready),
        .i_in_data   (fifo_in),
        .o_out_valid (o_link_valid),
        .i_out_ready (i_link_ready),
        .o_out_data  (fifo_out)
    );

    assign o_adc_ready  = fifo_ready;
    assign o_link_data  = fifo_out.data;
    assign o_link_point = fifo_out.point;

    // Checks
    a_mid_code: assert property (@(posedge i_clk) disable iff (i_rst)
        step && !conv_restart && !sample_test &&
        conv_code == pattern_gen_pkg::C_MID |=> conv_word == 14'h0000)
        else $error("midscale code gave nonzero word");
    a_pos_code: assert property (@(posedge i_clk) disable iff (i_rst)
        step && !conv_restart && !sample_test &&
        conv_code == pattern_gen_pkg::C_POS |=> conv_word == 14'h07FF)
        else $error("positive full scale word wrong");
    a_check_alt: assert property (@(posedge i_clk) disable iff (i_rst)
        step && !conv_restart && !sample_test && conv_phase &&
        conv_code == pattern_gen_pkg::C_CHECK |=> conv_word == 14'h0555)
        else $error("checkerboard second word wrong");
    a_toggle_alt: assert property (@(posedge i_clk) disable iff (i_rst)
        step && !conv_restart && !sample_test && !conv_phase &&
        conv_code == pattern_gen_pkg::C_TOG |=> conv_word == 14'h0FFF)
        else $error("toggle first word wrong");
    a_pn_held: assert property (@(posedge i_clk) disable iff (i_rst)
        pn_hold |=> conv_pn == $past(conv_seed))
        else $error("sequence not held at seed");
    a_single_end: assert property (@(posedge i_clk) disable iff (i_rst)
        conv_udone && step && !conv_restart && !sample_test &&
        conv_code == pattern_gen_pkg::C_USER |=> conv_word == 14'h0000)
        else $error("single user pass did not end in zeros");
    a_exit_soft: assert property (@(posedge i_clk) disable iff (i_rst)
        link_ctrl != 8'h00 && !soft_rst |=> link_ctrl != 8'h00)
        else $error("link test left without soft reset");
    a_ramp_width: assert property (@(posedge i_clk) disable iff (i_rst)
        link_code == pattern_gen_pkg::L_RAMP &&
        link_point == pattern_gen_pkg::P_SCR8 ##1
        link_code == pattern_gen_pkg::L_RAMP |-> link_ramp[15:8] == 8'h00)
        else $error("ramp exceeds octet width");
    a_seed_load: assert property (@(posedge i_clk) disable iff (i_rst)
        link_code != prev_link_code |=> link_pn == $past(link_seed))
        else $error("link sequence not restarted");
endmodule // pattern_gen

// ==== design/pattern_gen_pkg.sv ====
// Constants, register map and carrier types of the test pattern generator.
// Assumes one clock domain and a byte-wide register port.
// Functional notes
// - Static codes and ramp replace converter samples
// - Converter control bits 4 or 5 reset generators
// - Patterns run each clock the queue accepts, analog input ignored
// - Code 0100 alternates 0x0AAA and 0x0555
// - Code 0101 long sequence, x23+x18+1, seed 0x3AFF
// - Code 0110 short sequence, x9+x5+1, seed 0x0092
// - Code 0111 alternates 0x0FFF and 0x0000
// - Code 1000 sends four user words, repeat/single
// - Sample test bit sends raw converter samples
// - Link control: 4-bit pattern, 2-bit injection point
// - Three injection points: 16, 10, 8 bits
// - Point codes 00 sample, 01 10-bit, 10 8-bit
// - Codes 0001, 0010 alternate fixed word pairs
// - Codes 0011, 0100: 31-bit and 23-bit sequences
// - Codes 0101, 0110: 15-bit and 9-bit sequences
// - Code 0111: 7-bit sequence, seed 0x07
// - Code 1000: ramp sized by injection point
// - Code 1110: user words 1-4 repeating
// - Code 1111: user words once, then zeros
package pattern_gen_pkg;
    localparam logic [11:0] ADDR_SOFT_RESET = 12'h000;
    localparam logic [11:0] ADDR_CONV_TEST  = 12'h550;
    localparam logic [11:0] ADDR_USER_FIRST = 12'h551;
    localparam logic [11:0] ADDR_USER_LAST  = 12'h558;
    localparam logic [11:0] ADDR_SAMPLE_TST = 12'h571;
    localparam logic [11:0] ADDR_LINK_TEST  = 12'h573;
    localparam logic [11:0] ADDR_LINK_LAYER = 12'h574;
    localparam logic [7:0]  SOFT_RESET_CMD  = 8'h81;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam int          CONV_RST_BIT_A  = 4;
    localparam int          CONV_RST_BIT_B  = 5;
    localparam int          CONV_SINGLE_BIT = 7;
    localparam int          SAMPLE_TST_BIT  = 5;
    // Converter test codes
    localparam logic [3:0] C_MID   = 4'h1;
    localparam logic [3:0] C_POS   = 4'h2;
    localparam logic [3:0] C_NEG   = 4'h3;
    localparam logic [3:0] C_CHECK = 4'h4;
    localparam logic [3:0] C_PNL   = 4'h5;
    localparam logic [3:0] C_PNS   = 4'h6;
    localparam logic [3:0] C_TOG   = 4'h7;
    localparam logic [3:0] C_USER  = 4'h8;
    localparam logic [3:0] C_RAMP  = 4'hF;
    localparam logic [13:0] V_MID   = 14'h0000;
    localparam logic [13:0] V_POS   = 14'h07FF;
    localparam logic [13:0] V_NEG   = 14'h0800;
    localparam logic [13:0] V_CHK_A = 14'h0AAA;
    localparam logic [13:0] V_CHK_B = 14'h0555;
    localparam logic [13:0] V_TOG_A = 14'h0FFF;
    localparam logic [11:0] CONV_RAMP_MAX = 12'hFFF;
    // Link test codes
    localparam logic [3:0] L_CHECK = 4'h1;
    localparam logic [3:0] L_TOG   = 4'h2;
    localparam logic [3:0] L_PN31  = 4'h3;
    localparam logic [3:0] L_PN23  = 4'h4;
    localparam logic [3:0] L_PN15  = 4'h5;
    localparam logic [3:0] L_PN9   = 4'h6;
    localparam logic [3:0] L_PN7   = 4'h7;
    localparam logic [3:0] L_RAMP  = 4'h8;
    localparam logic [3:0] L_UREP  = 4'hE;
    localparam logic [3:0] L_USNG  = 4'hF;
    localparam logic [15:0] V_LCHK_A = 16'h5555;
    localparam logic [15:0] V_LCHK_B = 16'hAAAA;
    localparam logic [15:0] V_LTOG_B = 16'hFFFF;
    // Injection points
    localparam logic [1:0] P_SAMPLE = 2'b00;
    localparam logic [1:0] P_PHY10  = 2'b01;
    localparam logic [1:0] P_SCR8   = 2'b10;
    localparam logic [15:0] MASK_16 = 16'hFFFF;
    localparam logic [15:0] MASK_10 = 16'h03FF;
    localparam logic [15:0] MASK_8  = 16'h00FF;
    // Sequence lengths, taps and seeds
    localparam logic [31:0] SEED_PN31 = 32'h0003AFFF;
    localparam logic [31:0] SEED_PN23 = 32'h00003AFF;
    localparam logic [31:0] SEED_PN15 = 32'h000003AF;
    localparam logic [31:0] SEED_PN9  = 32'h00000092;
    localparam logic [31:0] SEED_PN7  = 32'h00000007;
    localparam int CONV_BITS = 14;
    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  point;
    } link_word_t;
endpackage

// ==== verif/link_sink.sv ====
// Link receiver model: takes every offered word and logs it.
// Assumes the bench raises i_stall to hold words back.
`timescale 1ns/100ps
module link_sink (
    input  wire logic        i_clk,
    input  wire logic        i_stall,
    input  wire logic        i_valid,
    input  wire logic [15:0] i_data,
    output logic             o_ready
);
    logic [15:0] words[$];
    assign o_ready = !i_stall;
    always @(posedge i_clk) begin
        if (i_valid && o_ready) words.push_back(i_data);
    end
endmodule // link_sink

// ==== verif/pattern_gen_bench.sv ====
// Self-checking bench for the test pattern generator.
// Assumes link_sink on the output stream and a free sample source.
`timescale 1ns/100ps
module pattern_gen_bench;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        wr = 1'b0, rd = 1'b0, stall = 1'b0, adc_valid = 1'b1;
    logic        ready, valid, adc_ready;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [15:0] data;
    logic [1:0]  point;
    int          errors = 0, total_checks = 0;
    logic [13:0] exp_a[5] = '{14'h0000, 14'h07FF, 14'h0800, 14'h0AAA, 14'h0FFF};
    logic [13:0] exp_b[5] = '{14'h0000, 14'h07FF, 14'h0800, 14'h0555, 14'h0000};
    logic [3:0]  codes[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    localparam logic [11:0] SR = pattern_gen_pkg::ADDR_SOFT_RESET;
    localparam logic [11:0] CT = pattern_gen_pkg::ADDR_CONV_TEST;
    localparam logic [11:0] LT = pattern_gen_pkg::ADDR_LINK_TEST;
    localparam logic [11:0] UF = pattern_gen_pkg::ADDR_USER_FIRST;
    always #2.5 i_clk = ~i_clk;
    pattern_gen dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_adc_valid(adc_valid), .i_adc_data(12'h5A3),
        .o_adc_ready(adc_ready), .o_link_valid(valid),
        .i_link_ready(ready), .o_link_data(data), .o_link_point(point));
    link_sink sink_u (.i_clk(i_clk), .i_stall(stall), .i_valid(valid),
        .i_data(data), .o_ready(ready));
    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clk);
        wr = 1'b1; addr = a; wdata = d;
        @(negedge i_clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(negedge i_clk);
        rd = 1'b1; addr = a;
        @(negedge i_clk);
        rd = 1'b0;
        @(negedge i_clk);
        check("rdata", {8'h00, rdata}, {8'h00, e});
    endtask
    // Two settled consecutive words must be the pair a, b in either phase
    task automatic pair(input logic [15:0] a, b);
        logic [15:0] x, y;
        repeat (40) @(negedge i_clk);
        sink_u.words.delete();
        repeat (4) @(negedge i_clk);
        x = sink_u.words[0];
        y = sink_u.words[1];
        if (x === a) check("word", y, b);
        else begin
            check("first", x, b);
            check("second", y, a);
        end
    endtask
    // With no samples offered the path drains; then a pattern is selected
    // and its first three words are checked
    task automatic first3(input logic [11:0] pa, input logic [7:0] pd,
                          input logic [11:0] a, input logic [7:0] d,
                          input logic [15:0] e0, e1, e2);
        adc_valid = 1'b0;
        wr_reg(pa, pd);
        repeat (20) @(negedge i_clk);
        sink_u.words.delete();
        check("idle", {15'h0000, valid}, 16'h0000);
        wr_reg(a, d);
        repeat (8) @(negedge i_clk);
        check("word0", sink_u.words[0], e0);
        check("word1", sink_u.words[1], e1);
        check("word2", sink_u.words[2], e2);
    endtask
    task automatic conclude;
        $display("Checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        conclude();
    end
    initial begin
        repeat (5) @(negedge i_clk);
        i_rst = 1'b0;
        rd_chk(pattern_gen_pkg::ADDR_LINK_TEST, 8'h00);
        rd_chk(12'h123, 8'h00);
        for (int k = 0; k < 5; k++) begin
            wr_reg(pattern_gen_pkg::ADDR_CONV_TEST, {4'h0, codes[k]});
            pair({exp_a[k], 2'b00}, {exp_b[k], 2'b00});
        end
        rd_chk(pattern_gen_pkg::ADDR_CONV_TEST, 8'h07);
        wr_reg(pattern_gen_pkg::ADDR_CONV_TEST, 8'h00);
        wr_reg(pattern_gen_pkg::ADDR_LINK_TEST, 8'h01);
        pair(16'h5555, 16'hAAAA);
        wr_reg(pattern_gen_pkg::ADDR_LINK_TEST, 8'h11);
        pair(16'h0155, 16'h02AA);
        check("point", {14'h0000, point}, 16'h0001);
        wr_reg(pattern_gen_pkg::ADDR_LINK_TEST, 8'h22);
        pair(16'h0000, 16'h00FF);
        stall = 1'b1;
        repeat (40) @(negedge i_clk);
        check("adc_ready", {15'h0000, adc_ready}, 16'h0000);
        stall = 1'b0;
        wr_reg(pattern_gen_pkg::ADDR_LINK_TEST, 8'h00);
        rd_chk(pattern_gen_pkg::ADDR_LINK_TEST, 8'h22);
        wr_reg(pattern_gen_pkg::ADDR_SOFT_RESET, 8'h81);
        rd_chk(pattern_gen_pkg::ADDR_LINK_TEST, 8'h00);
        rd_chk(pattern_gen_pkg::ADDR_SOFT_RESET, 8'h00);
        first3(SR, 8'h81, CT, 8'h05, 16'hFF5C, 16'h0008, 16'h9B80);
        first3(CT, 8'h15, CT, 8'h05, 16'hFF5C, 16'h0008, 16'h9B80);
        first3(SR, 8'h81, CT, 8'h06, 16'h496C, 16'hF268, 16'h9980);
        first3(SR, 8'h81, CT, 8'h0F, 16'h0000, 16'h0004, 16'h0008);
        first3(SR, 8'h81, LT, 8'h06, 16'h496F, 16'hC9A9, 16'h980C);
        first3(SR, 8'h81, LT, 8'h24, 16'h00FF, 16'h005C, 16'h0000);
        first3(SR, 8'h81, LT, 8'h28, 16'h0000, 16'h0001, 16'h0002);
        adc_valid = 1'b1;
        wr_reg(SR, 8'h81);
        for (int j = 0; j < 8; j++) begin
            wr_reg(UF + 12'(j), j[0] ? 8'h12 : 8'h34);
        end
        wr_reg(CT, 8'h08);
        pair(16'h1234, 16'h1234);
        wr_reg(CT, 8'h88);
        pair(16'h0000, 16'h0000);
        wr_reg(pattern_gen_pkg::ADDR_SAMPLE_TST, 8'h20);
        pair(16'h168C, 16'h168C);
        wr_reg(LT, 8'h1E);
        pair(16'h0048, 16'h0048);
        wr_reg(LT, 8'h1F);
        pair(16'h0000, 16'h0000);
        check("valid", {15'h0000, valid}, 16'h0001);
        conclude();
    end
endmodule // pattern_gen_bench
